// [hw/day_night_filter_control.sv]
// Day/night IR-cut filter position controller with AXI4-Lite registers
`timescale 1ns/10ps
`include "dn_filter_consts.svh"

module day_night_filter_control #(
  parameter int TICKS_PER_SECOND = `SECOND_NS / `CLK_PERIOD_NS,
  parameter int LEVEL_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Darkness measurement
  input wire logic signed [LEVEL_W-1:0] measured_darkness,
  // Filter actuator and I/O ports
  input wire logic position_select_input_function,
  output logic filter_night,
  output logic position_report_output_function
);
  import dn_filter_pkg::*;

  // ************************************************************
  // Reset synchroniser
  // ************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  mode_cfg_t mode_cfg;
  localparam logic [31:0] MODE_RESET_WORD = `MODE_RESET;
  logic signed [LEVEL_W-1:0] darkness_threshold;
  logic [15:0] transition_dwell_seconds;
  logic signed [LEVEL_W-1:0] level_reg;
  filter_status_t status;
  logic dwell_busy;
  logic dwell_done;

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] next_word;
  logic [31:0] old_word;
  logic wr_ok;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_comb begin
    old_word = 32'h0000_0000;
    wr_ok = 1'b1;
    case (aw_addr)
      `REG_MODE_OFS: begin
        old_word[`MODE_SEL_MSB:`MODE_SEL_LSB] = mode_cfg.sel;
        old_word[`MODE_REPORT_BIT] = mode_cfg.report_en;
        old_word[`MODE_PRESENT_BIT] = mode_cfg.present;
      end
      `REG_THRESHOLD_OFS: old_word = 32'(unsigned'(darkness_threshold));
      `REG_DWELL_OFS: old_word = {16'h0000, transition_dwell_seconds};
      default: wr_ok = 1'b0;
    endcase
  end

  // Byte lanes merged by strobe
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign next_word[lane*8 +: 8] = w_strb[lane] ? w_data[lane*8 +: 8] : old_word[lane*8 +: 8];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_cfg.sel <= MODE_RESET_WORD[`MODE_SEL_MSB:`MODE_SEL_LSB];
      mode_cfg.report_en <= MODE_RESET_WORD[`MODE_REPORT_BIT];
      mode_cfg.present <= MODE_RESET_WORD[`MODE_PRESENT_BIT];
    end else if (do_write && aw_addr == `REG_MODE_OFS) begin
      mode_cfg.sel <= next_word[`MODE_SEL_MSB:`MODE_SEL_LSB];
      mode_cfg.report_en <= next_word[`MODE_REPORT_BIT];
      mode_cfg.present <= next_word[`MODE_PRESENT_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      darkness_threshold <= LEVEL_W'(`THRESHOLD_RESET);
    end else if (do_write && aw_addr == `REG_THRESHOLD_OFS) begin
      darkness_threshold <= next_word[LEVEL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transition_dwell_seconds <= `DWELL_RESET;
    end else if (do_write && aw_addr == `REG_DWELL_OFS) begin
      transition_dwell_seconds <= next_word[15:0];
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `AXI_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      case (s_axi_araddr)
        `REG_MODE_OFS: begin
          s_axi_rdata[`MODE_SEL_MSB:`MODE_SEL_LSB] <= mode_cfg.sel;
          s_axi_rdata[`MODE_REPORT_BIT] <= mode_cfg.report_en;
          s_axi_rdata[`MODE_PRESENT_BIT] <= mode_cfg.present;
        end
        `REG_THRESHOLD_OFS: s_axi_rdata <= 32'(darkness_threshold);
        `REG_DWELL_OFS: s_axi_rdata <= {16'h0000, transition_dwell_seconds};
        `REG_LEVEL_OFS: s_axi_rdata <= 32'(level_reg);
        `REG_STATUS_OFS: begin
          s_axi_rdata[`STATUS_NIGHT_BIT] <= status.night;
          s_axi_rdata[`STATUS_DWELL_BIT] <= status.dwell_busy;
          s_axi_rdata[`STATUS_EXTERNAL_BIT] <= status.external;
        end
        default: s_axi_rresp <= `AXI_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Darkness sampling and comparison
  // ************************************************************
  logic is_dark;
  logic wants_move;
  filter_mode_t mode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= '0;
    end else begin
      level_reg <= measured_darkness;
    end
  end

  assign is_dark = level_reg > darkness_threshold;
  assign mode = filter_mode_t'(mode_cfg.sel);
  assign wants_move = mode == mode_auto && mode_cfg.present &&
    ((!filter_night && is_dark) || (filter_night && (level_reg < darkness_threshold)));

  dwell_timer #(
    .TICKS_PER_SECOND(TICKS_PER_SECOND)
  ) u_dwell (
    .clk(clk),
    .rst_n(rst_n),
    .run(wants_move),
    .seconds(transition_dwell_seconds),
    .expired(dwell_done),
    .busy(dwell_busy)
  );

  // ************************************************************
  // Filter position
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_night <= 1'b0;
    end else if (!mode_cfg.present) begin
      filter_night <= 1'b0;
    end else begin
      case (mode)
        mode_auto: if (dwell_done) filter_night <= !filter_night;
        mode_night: filter_night <= 1'b1;
        mode_day: filter_night <= 1'b0;
        mode_input: filter_night <= position_select_input_function;
        default: filter_night <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      position_report_output_function <= 1'b0;
    end else begin
      position_report_output_function <= mode_cfg.report_en && mode_cfg.present && filter_night;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status.night <= filter_night;
      status.dwell_busy <= dwell_busy;
      status.external <= !mode_cfg.present;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_forced_night: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == mode_night && mode_cfg.present) |=> filter_night)
    else $error("Forced night not applied");

  a_forced_day: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == mode_day && mode_cfg.present) |=> !filter_night)
    else $error("Forced day not applied");

  a_input_follow: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == mode_input && mode_cfg.present) |=> filter_night == $past(position_select_input_function))
    else $error("Input mode not followed");

  a_report_night: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_cfg.report_en && mode_cfg.present) |=> position_report_output_function == $past(filter_night))
    else $error("Report does not match position");

  a_external_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !mode_cfg.present |=> (!filter_night && !position_report_output_function))
    else $error("External filter moved or reported");

  a_auto_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == mode_auto && mode_cfg.present && !dwell_done) |=> $stable(filter_night))
    else $error("Auto moved before dwell");

  a_dark_start: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == mode_auto && mode_cfg.present && !filter_night && !is_dark) |-> !dwell_done)
    else $error("Night move without darkness");

  a_bright_start: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == mode_auto && mode_cfg.present && filter_night && level_reg >= darkness_threshold) |-> !dwell_done)
    else $error("Day move without brightness");

  a_level_read: assert property (@(posedge clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == `REG_LEVEL_OFS) |=>
      (s_axi_rvalid && s_axi_rdata == 32'($past(level_reg))))
    else $error("Level readback wrong");

endmodule : day_night_filter_control

// [hw/dwell_timer.sv]
// Seconds-based dwell timer with restart
`timescale 1ns/10ps
`include "dn_filter_consts.svh"

module dwell_timer #(
  parameter int TICKS_PER_SECOND = `CLK_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [15:0] seconds,
  // Result
  output logic expired,
  output logic busy
);
  import dn_filter_pkg::*;

  logic [31:0] tick;
  logic [15:0] secs;

  // ************************************************************
  // Counting
  // ************************************************************
  // restart when dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 32'h0000_0000;
      secs <= 16'h0000;
    end else if (!run || expired) begin
      tick <= 32'h0000_0000;
      secs <= 16'h0000;
    end else if (tick == 32'(TICKS_PER_SECOND - 1)) begin
      tick <= 32'h0000_0000;
      secs <= secs + 16'h0001;
    end else begin
      tick <= tick + 32'h0000_0001;
    end
  end

  assign expired = run && (secs >= seconds);
  assign busy = run && !expired;

endmodule : dwell_timer

// [inc/dn_filter_consts.svh]
// Constants for the day/night filter controller
`ifndef DN_FILTER_CONSTS_SVH
`define DN_FILTER_CONSTS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define REG_MODE_OFS 12'h000
`define REG_THRESHOLD_OFS 12'h004
`define REG_DWELL_OFS 12'h008
`define REG_LEVEL_OFS 12'h00C
`define REG_STATUS_OFS 12'h010

// ************************************************************
// Field positions and reset values
// ************************************************************
`define MODE_SEL_LSB 0
`define MODE_SEL_MSB 1
`define MODE_REPORT_BIT 4
`define MODE_PRESENT_BIT 5
`define MODE_RESET 32'h0000_0020
`define THRESHOLD_RESET 16'h0000
`define DWELL_RESET 16'h000A
`define STATUS_NIGHT_BIT 0
`define STATUS_DWELL_BIT 1
`define STATUS_EXTERNAL_BIT 2

// ************************************************************
// Timing and AXI response codes
// ************************************************************
`define CLK_HZ 200000000
`define SECOND_NS 1000000000
`define CLK_PERIOD_NS 5
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// [inc/dn_filter_pkg.sv]
// Types for the day/night filter controller
package dn_filter_pkg;

  typedef enum logic [1:0] {
    mode_auto,
    mode_night,
    mode_day,
    mode_input
  } filter_mode_t;

  typedef struct packed {
    logic [1:0] sel;
    logic report_en;
    logic present;
  } mode_cfg_t;

  typedef struct packed {
    logic night;
    logic dwell_busy;
    logic external;
  } filter_status_t;

endpackage : dn_filter_pkg

// [verification/day_night_filter_control_tb.sv]
// Self-checking bench for the filter controller
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, s); end end

module day_night_filter_control_tb;
  import dn_filter_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic signed [15:0] level_req = 0, measured_darkness;
  logic switch_req = 0, position_select_input_function, filter_night, position_report_output_function;
  logic [33:0] rd_q[$];
  logic [33:0] rd_exp;
  logic [31:0] lfsr = 32'h5029_f576;
  logic held;
  int failures = 0;
  int checks = 0;
  int i;
  logic [7:0] mode_tab [4] = '{8'h21, 8'h22, 8'h23, 8'h23};
  logic sw_tab [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic exp_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  always #2.5 clk = ~clk;

  day_night_filter_control #(.TICKS_PER_SECOND(10), .LEVEL_W(16)) day_night_filter_control_inst (
    .clk(clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .measured_darkness(measured_darkness),
    .position_select_input_function(position_select_input_function), .filter_night(filter_night),
    .position_report_output_function(position_report_output_function));

  filter_partner filter_partner_inst (
    .clk(clk), .level_req(level_req), .switch_req(switch_req),
    .position_report_output_function(position_report_output_function),
    .measured_darkness(measured_darkness),
    .position_select_input_function(position_select_input_function), .illuminator_on());

  // ************************************************************
  // Read result monitor
  // ************************************************************
  always @(posedge clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      rd_exp = rd_q.pop_front();
      `CHK("read", rd_exp, {s_axi_rresp, s_axi_rdata})
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic timed_out;
    failures++;
    $display("CHECK FAILED timeout expected 1 seen 0");
    final_report();
  endtask : timed_out

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic ta;
    logic tw;
    logic tb;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    tb = 0;
    for (n = 0; n < 50 && !tb; n++) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready === 1'b1;
      tw = s_axi_wvalid && s_axi_wready === 1'b1;
      tb = s_axi_bvalid === 1'b1;
      if (tb) `CHK("bresp", r, s_axi_bresp)
      @(posedge clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    if (!tb) timed_out();
    s_axi_bready <= 0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    int n;
    logic got;
    @(posedge clk);
    rd_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    got = 0;
    for (n = 0; n < 50 && !got; n++) begin
      @(negedge clk);
      got = s_axi_arready === 1'b1;
      @(posedge clk);
    end
    if (!got) timed_out();
    s_axi_arvalid <= 0;
    got = 0;
    for (n = 0; n < 50 && !got; n++) begin
      @(negedge clk);
      got = s_axi_rvalid === 1'b1;
      @(posedge clk);
    end
    if (!got) timed_out();
    s_axi_rready <= 0;
  endtask : rd

  task automatic wait_pos(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && filter_night !== v; n++) @(negedge clk);
    if (n == lim) timed_out();
  endtask : wait_pos

  task automatic idle(input int k);
    repeat (k) @(negedge clk);
  endtask : idle

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    rd(12'h000, {2'h0, 32'h0000_0020});
    rd(12'h004, {2'h0, 32'h0000_0000});
    rd(12'h008, {2'h0, 32'h0000_000a});
    rd(12'h010, {2'h0, 32'h0000_0000});
    rd(12'h020, {2'h2, 32'h0000_0000});
    wr(12'h020, 32'h0000_0001, 2'h2);
    $display("test registers done");
    wr(12'h008, 32'h0000_0001, 2'h0);
    wr(12'h004, 32'h0000_0064, 2'h0);
    rd(12'h004, {2'h0, 32'h0000_0064});
    level_req <= 16'sd50;
    idle(25);
    `CHK("below threshold", 1'b0, filter_night)
    lfsr = lfsr_next(lfsr);
    level_req <= 16'sd101 + $signed({9'h000, lfsr[6:0]});
    idle(6);
    level_req <= 16'sd100;
    @(posedge clk);
    level_req <= 16'sd200;
    idle(8);
    `CHK("restart", 1'b0, filter_night)
    wait_pos(1'b1, 20);
    `CHK("auto night", 1'b1, filter_night)
    rd(12'h010, {2'h0, 32'h0000_0001});
    level_req <= -16'sd50;
    idle(3);
    rd(12'h00c, {2'h0, 32'hffff_ffce});
    wait_pos(1'b0, 20);
    `CHK("auto day", 1'b0, filter_night)
    $display("test auto done");
    for (i = 0; i < 4; i++) begin
      switch_req <= sw_tab[i];
      wr(12'h000, {24'h0000_00, mode_tab[i]}, 2'h0);
      idle(4);
      `CHK("mode", exp_tab[i], filter_night)
    end
    wr(12'h000, 32'h0000_0031, 2'h0);
    idle(4);
    `CHK("report night", 1'b1, position_report_output_function)
    wr(12'h000, 32'h0000_0032, 2'h0);
    idle(4);
    `CHK("report day", 1'b0, position_report_output_function)
    wr(12'h000, 32'h0000_0011, 2'h0);
    idle(4);
    `CHK("report absent", 1'b0, position_report_output_function)
    wr(12'h000, 32'h0000_0010, 2'h0);
    held = filter_night;
    level_req <= 16'sd300;
    idle(30);
    `CHK("external hold", held, filter_night)
    rd(12'h000, {2'h0, 32'h0000_0010});
    rd(12'h010, {2'h0, 32'h0000_0004});
    $display("test modes done");
    final_report();
  end
endmodule : day_night_filter_control_tb

// [verification/filter_partner.sv]
// Scene sensor and I/O port model facing the filter controller
`timescale 1ns/10ps

module filter_partner (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic signed [15:0] level_req,
  input wire logic switch_req,
  // Report port observed
  input wire logic position_report_output_function,
  // Toward the controller; illuminator_on follows the report port
  output logic signed [15:0] measured_darkness,
  output logic position_select_input_function,
  output logic illuminator_on
);
  // ************************************************************
  // Scene level source
  // ************************************************************
  // signed darkness level
  always_ff @(posedge clk) begin
    measured_darkness <= level_req;
  end
  always_ff @(posedge clk) begin
    position_select_input_function <= switch_req;
  end
  always_ff @(posedge clk) begin
    illuminator_on <= position_report_output_function;
  end
endmodule : filter_partner
